// >>> core/tsc_dev.sv
// Purpose: Switch end: control register, block fill, drive control.
// Assumes: Host keeps the register bus rules; inputs are synchronous.
// Notes:   Connection memory is a reduced array of flip-flops.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_dev #(
  parameter int unsigned FRAME_CYCLES = `TSC_FRAME_CYC
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  tsc_if.dev                         bus,
  input  wire logic                  i_output_drive_pin,
  input  wire logic                  i_frame_eval_done,
  output logic                       o_tx_drive_en,
  output logic                       o_drive_indicator_pin,
  output logic [3:0]                 o_rate_select,
  output logic                       o_frame_eval_active,
  output logic [`TSC_CM_IDX_W-1:0]   o_slot
);
  tsc_pkg::tsc_word_t      switch_control;
  tsc_pkg::tsc_word_t      cm [`TSC_CM_DEPTH];
  tsc_pkg::tsc_fill_e      fill_state;
  tsc_pkg::tsc_fill_e      next_fill_state;
  logic [`TSC_CM_IDX_W-1:0] fill_idx;
  logic [1:0]              fill_frames;
  logic                    eval_done_q;
  logic                    frame;
  logic [`TSC_CM_IDX_W-1:0] slot;

  // Bus decode
  wire wr_ctrl  = bus.wr && (bus.addr == `TSC_CTRL_ADDR);
  wire rd_ctrl  = bus.rd && (bus.addr == `TSC_CTRL_ADDR);
  wire rd_stat  = bus.rd && (bus.addr == `TSC_STAT_ADDR);
  wire cm_sel   = bus.addr[`TSC_CM_SEL_BIT]
               && (bus.addr[`TSC_CM_SEL_BIT-1:`TSC_CM_IDX_W] == '0);
  wire [`TSC_CM_IDX_W-1:0] cm_idx = bus.addr[`TSC_CM_IDX_W-1:0];
  wire wr_cm    = bus.wr && cm_sel;
  wire rd_cm    = bus.rd && cm_sel;

  // A soft reset acts on the same edge as the write that carries it
  wire soft_rst = wr_ctrl && bus.wdata[`TSC_B_SRST];

  // Fill starts on a rising go bit written together with the arm bit
  wire go_rise  = wr_ctrl && bus.wdata[`TSC_B_GO] && !switch_control[`TSC_B_GO]
               && bus.wdata[`TSC_B_ARM];
  wire fill_on  = (fill_state != tsc_pkg::FILL_IDLE);
  wire fill_end = fill_on && frame && (fill_frames == `TSC_FILL_FRAMES - 2'h1);
  wire [2:0] fill_val = switch_control[`TSC_B_FILL_HI:`TSC_B_FILL_LO];
  wire tsc_pkg::tsc_word_t fill_word = {fill_val, `TSC_CM_LOW_ZERO};
  wire sweep_wr = (fill_state == tsc_pkg::FILL_SWEEP);

  wire eval_rise = wr_ctrl && bus.wdata[`TSC_B_EVAL] && !switch_control[`TSC_B_EVAL];
  wire eval_stop = i_frame_eval_done && !eval_done_q;

  // Drive decision for the channel now on the line
  wire [1:0] slot_mode = cm[slot][`TSC_CM_MODE_HI:`TSC_CM_MODE_LO];
  wire drive_any  = i_output_drive_pin || switch_control[`TSC_B_STBY];
  wire drive_now  = drive_any && (slot_mode != `TSC_CM_MODE_HIZ);
  wire indicator  = switch_control[`TSC_B_POL] ? drive_now : !drive_now;

  wire tsc_pkg::tsc_word_t stat_word =
    {14'h0000, o_frame_eval_active, fill_on};
  wire tsc_pkg::tsc_word_t next_rdata =
    rd_ctrl ? switch_control :
    rd_stat ? stat_word :
    rd_cm   ? cm[cm_idx] : 16'h0000;

  tsc_frame_timer #(
    .FRAME_CYCLES (FRAME_CYCLES)
  ) tsc_frame_timer_inst (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_clr   (soft_rst),
    .o_frame (frame),
    .o_slot  (slot)
  );

  // Control register; the write wins over the self-clear of the go bit
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      switch_control <= `TSC_CTRL_RESET;
    end else if (soft_rst) begin
      switch_control <= `TSC_CTRL_RESET;
    end else if (wr_ctrl) begin
      switch_control <= bus.wdata;
    end else if (fill_end) begin
      switch_control[`TSC_B_GO] <= 1'b0;
    end
  end

  always_comb begin
    next_fill_state = fill_state;
    unique case (fill_state)
      tsc_pkg::FILL_IDLE: begin
        if (go_rise) begin
          next_fill_state = tsc_pkg::FILL_SWEEP;
        end
      end
      tsc_pkg::FILL_SWEEP: begin
        if (fill_end) begin
          next_fill_state = tsc_pkg::FILL_IDLE;
        end else if (&fill_idx) begin
          next_fill_state = tsc_pkg::FILL_WAIT;
        end
      end
      tsc_pkg::FILL_WAIT: begin
        if (fill_end) begin
          next_fill_state = tsc_pkg::FILL_IDLE;
        end
      end
      default: next_fill_state = tsc_pkg::FILL_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fill_state  <= tsc_pkg::FILL_IDLE;
      fill_idx    <= '0;
      fill_frames <= 2'h0;
    end else if (soft_rst) begin
      fill_state  <= tsc_pkg::FILL_IDLE;
      fill_idx    <= '0;
      fill_frames <= 2'h0;
    end else begin
      fill_state  <= next_fill_state;
      fill_idx    <= sweep_wr ? fill_idx + 1'b1 : '0;
      // Frames are counted from the start edge, so two frame marks pass
      if (!fill_on) begin
        fill_frames <= 2'h0;
      end else if (frame) begin
        fill_frames <= fill_frames + 2'h1;
      end
    end
  end

  // Connection memory: the sweep has priority over host writes,
  // which the host is not allowed to make while the fill runs.
  genvar gi;
  generate
    for (gi = 0; gi < `TSC_CM_DEPTH; gi++) begin : g_cm
      wire sweep_hit = sweep_wr && (fill_idx == gi);
      wire host_hit  = wr_cm && (cm_idx == gi);
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          cm[gi] <= 16'h0000;
        end else if (soft_rst) begin
          cm[gi] <= 16'h0000;
        end else if (sweep_hit) begin
          cm[gi] <= fill_word;
        end else if (host_hit) begin
          cm[gi] <= bus.wdata;
        end
      end
    end
  endgenerate

  // Evaluation runs until the done flag rises; a new start wins
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_frame_eval_active <= 1'b0;
      eval_done_q         <= 1'b0;
    end else begin
      eval_done_q <= i_frame_eval_done;
      if (soft_rst) begin
        o_frame_eval_active <= 1'b0;
      end else if (eval_rise) begin
        o_frame_eval_active <= 1'b1;
      end else if (eval_stop) begin
        o_frame_eval_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_drive_en         <= 1'b0;
      o_drive_indicator_pin <= 1'b1;
      o_rate_select         <= 4'h0;
      o_slot                <= '0;
      bus.rdata             <= 16'h0000;
      bus.frame             <= 1'b0;
      bus.fill_busy         <= 1'b0;
    end else begin
      o_tx_drive_en         <= drive_now;
      o_drive_indicator_pin <= indicator;
      o_rate_select         <= switch_control[`TSC_B_RATE_HI:`TSC_B_RATE_LO];
      o_slot                <= slot;
      bus.rdata             <= next_rdata;
      bus.frame             <= frame;
      bus.fill_busy         <= fill_on || go_rise;
    end
  end
endmodule : tsc_dev

// >>> core/tsc_frame_timer.sv
// Purpose: Frame and channel slot timing of the switch.
// Assumes: FRAME_CYCLES is a whole multiple of the memory depth.
// Notes:   Restarts from slot 0 on i_clr.
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_frame_timer #(
  parameter int unsigned FRAME_CYCLES = `TSC_FRAME_CYC
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst,
  input  wire logic                     i_clr,
  output logic                          o_frame,
  output logic [`TSC_CM_IDX_W-1:0]      o_slot
);
  localparam int unsigned SLOT_CYC = FRAME_CYCLES / `TSC_CM_DEPTH;
  localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYC - 1);

  logic [15:0] cyc;
  wire         slot_end  = (cyc == SLOT_LAST);
  wire         frame_end = slot_end && (&o_slot);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cyc     <= 16'h0000;
      o_slot  <= '0;
      o_frame <= 1'b0;
    end else if (i_clr) begin
      cyc     <= 16'h0000;
      o_slot  <= '0;
      o_frame <= 1'b0;
    end else begin
      cyc     <= slot_end ? 16'h0000 : cyc + 16'h0001;
      o_slot  <= slot_end ? o_slot + 1'b1 : o_slot;
      o_frame <= frame_end;
    end
  end
endmodule : tsc_frame_timer

// >>> core/tsc_host.sv
// Purpose: Host end: forwards user accesses and keeps the host duties.
// Assumes: Device answers reads one cycle after the strobe.
// Notes:   Refused requests are dropped and flagged for one cycle.
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_host (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  tsc_if.host                         bus,
  input  wire logic [`TSC_ADDR_W-1:0] i_addr,
  input  wire logic [15:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [15:0]                 o_rdata,
  output logic                        o_rdata_valid,
  output logic                        o_refused
);
  tsc_pkg::tsc_host_e state;
  logic [7:0]         hold_cnt;
  logic               eval_shadow;
  logic [1:0]         eval_low_frames;
  logic               rd_q;
  logic               rd_qq;

  localparam logic [7:0] HOLD_LAST = 8'(`TSC_RST_HOLD_CYC - 1);

  wire is_ctrl   = (i_addr == `TSC_CTRL_ADDR);
  wire ctrl_wr   = i_wr && is_ctrl;
  // A go write still on the bus raises busy only one edge later
  wire go_pend   = bus.wr && (bus.addr == `TSC_CTRL_ADDR) && bus.wdata[`TSC_B_GO];
  wire busy_fill = (bus.fill_busy || go_pend) && ctrl_wr;
  wire eval_bad  = ctrl_wr && i_wdata[`TSC_B_EVAL] && !eval_shadow
                && (eval_low_frames != `TSC_EVAL_GAP);
  wire held      = (state == tsc_pkg::HOST_HOLD);
  wire refuse    = (i_wr || i_rd) && (held || busy_fill || eval_bad);
  wire take_wr   = i_wr && !refuse;
  wire take_rd   = i_rd && !i_wr && !refuse;
  wire soft_go   = take_wr && is_ctrl && i_wdata[`TSC_B_SRST];

  // Fixed bits are forced on the way out
  wire tsc_pkg::tsc_word_t ctrl_out = (i_wdata | (16'h0001 << `TSC_B_FIXED1))
    & ~((16'h0001 << `TSC_B_RSV12) | (16'h0001 << `TSC_B_RSV10));
  wire tsc_pkg::tsc_word_t next_wdata = is_ctrl ? ctrl_out : i_wdata;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bus.addr  <= '0;
      bus.wdata <= 16'h0000;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      o_refused <= 1'b0;
    end else begin
      bus.addr  <= (take_wr || take_rd) ? i_addr : bus.addr;
      bus.wdata <= take_wr ? next_wdata : bus.wdata;
      bus.wr    <= take_wr;
      bus.rd    <= take_rd;
      o_refused <= refuse;
    end
  end

  // After a soft reset the bit stays low for the hold time
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state    <= tsc_pkg::HOST_READY;
      hold_cnt <= 8'h00;
    end else begin
      unique case (state)
        tsc_pkg::HOST_READY: begin
          if (soft_go) begin
            state    <= tsc_pkg::HOST_HOLD;
            hold_cnt <= 8'h00;
          end
        end
        tsc_pkg::HOST_HOLD: begin
          hold_cnt <= hold_cnt + 8'h01;
          if (hold_cnt == HOLD_LAST) begin
            state <= tsc_pkg::HOST_READY;
          end
        end
      endcase
    end
  end

  // Two frame marks with the bit low make one full frame
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      eval_shadow     <= 1'b0;
      eval_low_frames <= `TSC_EVAL_GAP;
    end else if (take_wr && is_ctrl) begin
      eval_shadow     <= i_wdata[`TSC_B_EVAL] && !i_wdata[`TSC_B_SRST];
      eval_low_frames <= (i_wdata[`TSC_B_EVAL] || eval_shadow) ? 2'h0 : eval_low_frames;
    end else if (bus.frame && !eval_shadow && eval_low_frames != `TSC_EVAL_GAP) begin
      eval_low_frames <= eval_low_frames + 2'h1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_q          <= 1'b0;
      rd_qq         <= 1'b0;
      o_rdata       <= 16'h0000;
      o_rdata_valid <= 1'b0;
    end else begin
      rd_q          <= take_rd;
      rd_qq         <= rd_q;
      o_rdata_valid <= rd_qq;
      o_rdata       <= rd_qq ? bus.rdata : o_rdata;
    end
  end
endmodule : tsc_host

// >>> core/tsc_if.sv
// Purpose: Register bus and frame status between host and switch.
// Assumes: One clock; all signals change after a rising edge.
// Notes:   Read data stand the cycle after the read strobe.
`timescale 1ns/1ps
`include "tsc_params.svh"
interface tsc_if;
  logic [`TSC_ADDR_W-1:0] addr;
  tsc_pkg::tsc_word_t     wdata;
  logic                   wr;
  logic                   rd;
  tsc_pkg::tsc_word_t     rdata;
  logic                   frame;
  logic                   fill_busy;

  modport dev  (input addr, wdata, wr, rd, output rdata, frame, fill_busy);
  modport host (output addr, wdata, wr, rd, input rdata, frame, fill_busy);
endinterface : tsc_if

// >>> core/tsc_params.svh
// Purpose: Shared constants of the switch control register block.
// Assumes: 50 MHz clock; a 125 us frame.
// Notes:   Offsets and field positions are used by both ends.
// Function
// - Bit 15 resets device; host keeps it zero.
// - Host always writes bit 14 as one.
// - Bit 13 sets drive indicator pin polarity.
// - Host writes bits 12 and 10 as zero.
// - Bit 11 arms connection memory block programming.
// - Fill loads bits 15-13, clears bits 12-0.
// - Bit 6 rise starts fill; one write.
// - Fill lasts two frames, then bit 6 clears.
// - Host changes nothing while bit 6 set; the host refuses only control writes during a fill and passes memory writes.
// - Drive pin and standby low: drivers high impedance.
// - Otherwise drive, except channels with mode 11.
// - Bit 4 rise starts evaluation; done stops it.
// - Host holds bit 4 low one frame first.
// - Bits 3-0 select rate and switching mode.
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

`define TSC_ADDR_W       8
`define TSC_DATA_W       16
`define TSC_CTRL_ADDR    8'h00
`define TSC_STAT_ADDR    8'h01
`define TSC_CM_SEL_BIT   7
`define TSC_CM_DEPTH     32
`define TSC_CM_IDX_W     5
`define TSC_CTRL_RESET   16'h4000
`define TSC_B_SRST       15
`define TSC_B_FIXED1     14
`define TSC_B_POL        13
`define TSC_B_RSV12      12
`define TSC_B_ARM        11
`define TSC_B_RSV10      10
`define TSC_B_FILL_HI    9
`define TSC_B_FILL_LO    7
`define TSC_B_GO         6
`define TSC_B_STBY       5
`define TSC_B_EVAL       4
`define TSC_B_RATE_HI    3
`define TSC_B_RATE_LO    0
`define TSC_CM_MODE_HI   14
`define TSC_CM_MODE_LO   13
`define TSC_CM_MODE_HIZ  2'h3
`define TSC_CM_LOW_ZERO  13'h0000
`define TSC_S_FILL       0
`define TSC_S_EVAL       1
`define TSC_FILL_FRAMES  2'h2
`define TSC_EVAL_GAP     2'h2
`define TSC_CLK_MHZ      50
`define TSC_FRAME_NS     125000
`define TSC_RST_HOLD_NS  100
`define TSC_FRAME_CYC    ((`TSC_FRAME_NS * `TSC_CLK_MHZ) / 1000)
`define TSC_RST_HOLD_CYC ((`TSC_RST_HOLD_NS * `TSC_CLK_MHZ + 999) / 1000)

`endif

// >>> core/tsc_pkg.sv
// Purpose: Types shared by both ends.
// Assumes: Constants come from tsc_params.svh.
// Notes:   None.
package tsc_pkg;
  typedef logic [15:0] tsc_word_t;
  typedef enum logic [1:0] {FILL_IDLE, FILL_SWEEP, FILL_WAIT} tsc_fill_e;
  typedef enum logic {HOST_READY, HOST_HOLD} tsc_host_e;
endpackage : tsc_pkg

// >>> tb/tsc_asserts.sv
// Purpose: Assertions on the bus between host and switch ends.
// Assumes: Fill start needs go low before; unarmed go is tracked.
// Notes:   Watches interface signals only.
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_asserts (
  input wire logic                   i_mclk,
  input wire logic                   i_rst,
  input wire logic [`TSC_ADDR_W-1:0] i_addr,
  input wire tsc_pkg::tsc_word_t     i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire tsc_pkg::tsc_word_t     i_rdata,
  input wire logic                   i_frame,
  input wire logic                   i_fill_busy
);
  logic [1:0] fcnt;
  logic       last_go;
  logic       busy_q;
  wire        ctrl_wr = i_wr && (i_addr == `TSC_CTRL_ADDR);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Go stored without arm stays set, so a rewrite of it is no rising edge
  // A frame mark in the first busy cycle came before the start edge: not counted
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fcnt    <= 2'h0;
      last_go <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      busy_q  <= i_fill_busy;
      fcnt    <= !i_fill_busy ? 2'h0 : fcnt + 2'(i_frame && busy_q);
      last_go <= ctrl_wr ? i_wdata[`TSC_B_GO] & !i_wdata[`TSC_B_SRST]
                         : last_go & !i_fill_busy;
    end
  end
  a_bit14_set: assert property (ctrl_wr |-> i_wdata[`TSC_B_FIXED1])
    else $error("bit14 low");
  a_unused_zero: assert property (ctrl_wr |-> !i_wdata[`TSC_B_RSV12] && !i_wdata[`TSC_B_RSV10])
    else $error("unused bit set");
  a_no_ctrl_busy: assert property (ctrl_wr |-> !$past(i_fill_busy))
    else $error("control write in fill");
  a_fill_start: assert property (ctrl_wr && !i_wdata[`TSC_B_SRST] && i_wdata[`TSC_B_ARM]
    && i_wdata[`TSC_B_GO] && !last_go |=> i_fill_busy) else $error("fill not started");
  a_fill_unarmed: assert property (ctrl_wr && !i_wdata[`TSC_B_ARM] && !i_fill_busy
    |=> !i_fill_busy) else $error("fill without arm");
  a_fill_frames: assert property ($fell(i_fill_busy) |-> fcnt == `TSC_FILL_FRAMES)
    else $error("fill length wrong");
  a_fill_stop: assert property (i_fill_busy && fcnt == `TSC_FILL_FRAMES |=> !i_fill_busy)
    else $error("fill overran");
  a_ctrl_readback: assert property (i_rd && i_addr == `TSC_CTRL_ADDR
    |=> i_rdata[15:14] == 2'h1) else $error("control read bad");
  a_soft_quiet: assert property (ctrl_wr && i_wdata[`TSC_B_SRST] |=> !(i_wr || i_rd) [*5])
    else $error("access after soft reset");
  c_fill: cover property ($fell(i_fill_busy));
  c_soft: cover property (ctrl_wr && i_wdata[`TSC_B_SRST]);
  c_read: cover property (i_rd && i_addr == `TSC_STAT_ADDR);
endmodule : tsc_asserts

// >>> tb/tsi_switch_control_register_tb.sv
// Purpose: Drives user accesses through host into switch end.
// Assumes: Frame of 64 cycles to keep fills short.
// Notes:   Expected values follow the control bit layout.
`timescale 1ns/1ps
module tsi_switch_control_register_tb;
  logic        i_mclk  = 1'b0;
  logic        i_rst   = 1'b1;
  logic [7:0]  u_addr  = 8'h00;
  logic [15:0] u_wdata = 16'h0000;
  logic        u_wr    = 1'b0;
  logic        u_rd    = 1'b0;
  logic        pin     = 1'b0;
  logic        done    = 1'b0;
  logic [15:0] u_rdata;
  logic        u_valid;
  logic        u_ref;
  logic        tx_en;
  logic        ind;
  logic        ev;
  logic [3:0]  rate;
  logic [4:0]  slt;
  logic [15:0] rv;
  logic        rf;
  int          fails      = 0;
  int          num_checks = 0;
  tsc_if bus ();
  tsc_dev #(.FRAME_CYCLES(64)) tsc_dev_inst (.i_mclk(i_mclk), .i_rst(i_rst), .bus(bus.dev),
    .i_output_drive_pin(pin), .i_frame_eval_done(done), .o_tx_drive_en(tx_en),
    .o_drive_indicator_pin(ind), .o_rate_select(rate), .o_frame_eval_active(ev), .o_slot(slt));
  tsc_host tsc_host_inst (.i_mclk(i_mclk), .i_rst(i_rst), .bus(bus.host), .i_addr(u_addr),
    .i_wdata(u_wdata), .i_wr(u_wr), .i_rd(u_rd), .o_rdata(u_rdata), .o_rdata_valid(u_valid),
    .o_refused(u_ref));
  tsc_asserts tsc_asserts_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(bus.addr),
    .i_wdata(bus.wdata), .i_wr(bus.wr), .i_rd(bus.rd), .i_rdata(bus.rdata),
    .i_frame(bus.frame), .i_fill_busy(bus.fill_busy));
  always #10 i_mclk = ~i_mclk;
  task automatic give_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic settle();
    repeat (3) @(posedge i_mclk);
    #1;
  endtask : settle
  // Refusal shows just after the same edge at which the host samples the request
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    u_addr  <= a;
    u_wdata <= d;
    u_wr    <= 1'b1;
    @(posedge i_mclk);
    u_wr <= 1'b0;
    #1 rf = u_ref;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    int n;
    @(posedge i_mclk);
    u_addr <= a;
    u_rd   <= 1'b1;
    @(posedge i_mclk);
    u_rd <= 1'b0;
    #1 rf = u_ref;
    n = 0;
    while (!u_valid && !rf) begin
      @(posedge i_mclk);
      #1;
      n++;
      if (n > 8) begin
        fails++;
        give_verdict();
      end
    end
    rv = u_rdata;
  endtask : rd_reg
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (bus.fill_busy !== lvl) begin
      @(posedge i_mclk);
      #1;
      n++;
      if (n > 300) begin
        fails++;
        give_verdict();
      end
    end
  endtask : wait_busy
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd_reg(8'h00);
    chk("ctrl", rv, 16'h4000);
    chk("en", 16'(tx_en), 16'h0000);
    chk("ind", 16'(ind), 16'h0001);
    for (int r = 0; r < 12; r++) begin
      wr_reg(8'h00, 16'h4000 | 16'(r));
      chk("rate", 16'(rate), 16'(r));
    end
    rd_reg(8'h00);
    chk("ctrl", rv, 16'h400b);
    wr_reg(8'h00, 16'h6000);
    chk("ind", 16'(ind), 16'h0000);
    @(posedge i_mclk);
    pin <= 1'b1;
    settle();
    chk("en", 16'(tx_en), 16'h0001);
    chk("ind", 16'(ind), 16'h0001);
    @(posedge i_mclk);
    pin <= 1'b0;
    wr_reg(8'h00, 16'h4020);
    settle();
    chk("en", 16'(tx_en), 16'h0001);
    chk("ind", 16'(ind), 16'h0000);
    wr_reg(8'h00, 16'h4000);
    settle();
    chk("en", 16'(tx_en), 16'h0000);
    wr_reg(8'h00, 16'h43c0);
    settle();
    chk("busy", 16'(bus.fill_busy), 16'h0000);
    wr_reg(8'h00, 16'h4000);
    @(posedge i_mclk);
    pin <= 1'b1;
    wr_reg(8'h00, 16'h49c0);
    chk("busy", 16'(bus.fill_busy), 16'h0001);
    rd_reg(8'h01);
    chk("status", rv, 16'h0001);
    wr_reg(8'h00, 16'h4000);
    chk("refused", 16'(rf), 16'h0001);
    wait_busy(1'b0);
    rd_reg(8'h00);
    chk("ctrl", rv, 16'h4980);
    rd_reg(8'h80);
    chk("cm0", rv, 16'h6000);
    rd_reg(8'h9f);
    chk("cm31", rv, 16'h6000);
    // Every word now has mode 11, so no slot may drive
    for (int i = 0; i < 40; i++) begin
      @(posedge i_mclk);
      #1;
      chk("en", 16'(tx_en), 16'h0000);
    end
    wr_reg(8'h00, 16'h4010);
    chk("eval", 16'(ev), 16'h0001);
    @(posedge i_mclk);
    done <= 1'b1;
    settle();
    chk("eval", 16'(ev), 16'h0000);
    @(posedge i_mclk);
    done <= 1'b0;
    wr_reg(8'h00, 16'h4000);
    wr_reg(8'h00, 16'h4010);
    chk("refused", 16'(rf), 16'h0001);
    repeat (140) @(posedge i_mclk);
    wr_reg(8'h00, 16'h4010);
    chk("eval", 16'(ev), 16'h0001);
    wr_reg(8'h00, 16'hc023);
    chk("slot", 16'(slt), 16'h0000);
    rd_reg(8'h00);
    chk("refused", 16'(rf), 16'h0001);
    rd_reg(8'h00);
    chk("ctrl", rv, 16'h4000);
    chk("eval", 16'(ev), 16'h0000);
    rd_reg(8'h80);
    chk("cm0", rv, 16'h0000);
    wr_reg(8'h81, 16'h6000);
    rd_reg(8'h81);
    chk("cm1", rv, 16'h6000);
    rd_reg(8'h02);
    chk("hole", rv, 16'h0000);
    wr_reg(8'h05, 16'hffff);
    rd_reg(8'h00);
    chk("ctrl", rv, 16'h4000);
    give_verdict();
  end
endmodule : tsi_switch_control_register_tb
